/* File: rtl/spindle_io_pkg.sv */
// Constants shared by the spindle external I/O block
// Function
// - Rotation sense open clockwise, closed counterclockwise
// - Step pulse edge changes setpoint 200/1000
// - Release toggle clears error once cause gone
// - Keep error, ignore release while cause present
// - Selector attached: choice bits pick motor
// - No selector, preset mode: bits pick slot
// - Run output closed while rotating by default
// - Inversion option: run output closed while stopped
// - Shared output shows direction under rotate command
// - Shared output shows motor one or two
// - Fault closed normally, open on error
// - Fault output polarity selectable
// - Fault output may carry patterned error code
// - Spindle choice open motor one, closed two
// - Polarity closed raises, open lowers setpoint
// - Choice pair decodes to slots one..four
// - Rotate command closed starts, open stops
package spindle_io_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_US = 100;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int PATTERN_UNIT_MS = 250;
  localparam int PATTERN_UNIT_CYC = PATTERN_UNIT_MS * (CLK_HZ / 1000);
  localparam int PATTERN_GAP_UNITS = 4;
  localparam int NUM_INPUTS = 8;
  // Input vector positions after conditioning
  localparam int IN_SENSE = 0;
  localparam int IN_STEP = 1;
  localparam int IN_POL = 2;
  localparam int IN_REL = 3;
  localparam int IN_CB0 = 4;
  localparam int IN_CB1 = 5;
  localparam int IN_SPINDLE = 6;
  localparam int IN_ROTATE = 7;
  // Speed arithmetic in rpm
  localparam int RPM_W = 17;
  localparam logic [RPM_W-1:0] STEP_SMALL = 17'h000C8;
  localparam logic [RPM_W-1:0] STEP_LARGE = 17'h003E8;
  localparam logic [RPM_W-1:0] RPM_MIN = 17'h003E8;
  localparam logic [RPM_W-1:0] RPM_MAX = 17'h13880;
  localparam logic [RPM_W-1:0] RPM_RESET = 17'h003E8;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SLOT0 = 12'h004;
  localparam logic [11:0] ADDR_SLOT1 = 12'h008;
  localparam logic [11:0] ADDR_SLOT2 = 12'h00C;
  localparam logic [11:0] ADDR_SLOT3 = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_SETPOINT = 12'h018;
  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CB_LARGE_STEP = 0;
  localparam int CB_RUN_INVERT = 1;
  localparam int CB_SHARED_MOTOR = 2;
  localparam int CB_FAULT_INVERT = 3;
  localparam int CB_FAULT_PATTERN = 4;
  localparam int CB_SELECTOR = 5;
  localparam int CB_PRESET_MODE = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
endpackage : spindle_io_pkg

/* File: rtl/input_conditioner.sv */
// Two-flop synchroniser and debounce filter for each external input
`timescale 1ns/100ps
module input_conditioner #(
  parameter int N = 8,
  parameter int CYC = 1000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] clean
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic [15:0] cnt_q;
      // Sync stage; s1_q feeds only s2_q
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= raw[i];
          s2_q <= s1_q;
        end
      end
      // Accept a new level only after it held still for CYC cycles; contact bounce is swallowed
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cnt_q <= 16'h0000;
          clean[i] <= 1'b0;
        end else if (s2_q == clean[i]) begin
          cnt_q <= 16'h0000;
        end else if (cnt_q == 16'(CYC - 1)) begin
          cnt_q <= 16'h0000;
          clean[i] <= s2_q;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  endgenerate
endmodule : input_conditioner

/* File: rtl/fault_pattern.sv */
// Blink pattern generator: error code as a train of pulses then a gap
`timescale 1ns/100ps
module fault_pattern #(
  parameter int UNIT_CYC = 2500000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [3:0] code,
  output logic pulse_q
);
  typedef enum logic [1:0] {P_IDLE, P_ON, P_OFF, P_GAP} pat_state_t;
  pat_state_t state_q;
  logic [31:0] timer_q;
  logic [3:0] left_q;
  logic [3:0] gap_q;
  logic tick;

  assign tick = (timer_q == 32'(UNIT_CYC - 1));

  // Unit timer restarts whenever the pattern is idle
  always_ff @(posedge mclk) begin
    if (!rst_n || state_q == P_IDLE || tick) begin
      timer_q <= 32'h00000000;
    end else begin
      timer_q <= timer_q + 32'h00000001;
    end
  end

  // One unit on, one unit off per count, then a long gap; a zero code still gives one pulse
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= P_IDLE;
      left_q <= 4'h0;
      gap_q <= 4'h0;
      pulse_q <= 1'b0;
    end else if (!active) begin
      state_q <= P_IDLE;
      pulse_q <= 1'b0;
    end else begin
      unique case (state_q)
        P_IDLE: begin
          state_q <= P_ON;
          left_q <= (code == 4'h0) ? 4'h1 : code;
          pulse_q <= 1'b1;
        end
        P_ON: if (tick) begin
          state_q <= P_OFF;
          pulse_q <= 1'b0;
          left_q <= left_q - 4'h1;
        end
        P_OFF: if (tick) begin
          if (left_q == 4'h0) begin
            state_q <= P_GAP;
            gap_q <= 4'(spindle_io_pkg::PATTERN_GAP_UNITS - 1);
          end else begin
            state_q <= P_ON;
            pulse_q <= 1'b1;
          end
        end
        P_GAP: if (tick) begin
          if (gap_q == 4'h0) begin
            state_q <= P_IDLE;
          end else begin
            gap_q <= gap_q - 4'h1;
          end
        end
      endcase
    end
  end
endmodule : fault_pattern

/* File: rtl/spindle_external_io.sv */
// External connector logic of the spindle controller with APB configuration
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module spindle_external_io #(
  parameter int PATTERN_CYC = spindle_io_pkg::PATTERN_UNIT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Connector inputs, 1 = closed
  input wire logic rotation_sense_in,
  input wire logic speed_step_pulse,
  input wire logic step_polarity_input,
  input wire logic error_release_in,
  input wire logic choice_bit_zero,
  input wire logic choice_bit_one,
  input wire logic spindle_choice_input,
  input wire logic rotate_cmd_in,
  // From the rest of the controller
  input wire logic motor_rotating,
  input wire logic error_cause,
  input wire logic [7:0] error_code,
  // Connector outputs, 1 = closed
  output logic run_status_out,
  output logic shared_status_out,
  output logic fault_out,
  // To the rest of the controller
  output logic motor_start,
  output logic counter_sense,
  output logic [1:0] active_spindle_flag,
  output logic [1:0] preset_speed_slot,
  output logic [16:0] speed_setpoint,
  output logic error_latched,
  output logic display_error,
  output logic [7:0] display_code
);
  localparam int W = spindle_io_pkg::RPM_W;

  logic [spindle_io_pkg::NUM_INPUTS-1:0] raw;
  logic [spindle_io_pkg::NUM_INPUTS-1:0] cin;
  logic [spindle_io_pkg::CTRL_W-1:0] ctrl_q;
  logic [W-1:0] slot_q [4];
  logic step_prev_q;
  logic rel_prev_q;
  logic rel_armed_q;
  logic err_q;
  logic [W-1:0] pulse_sp_q;
  logic pattern;
  logic step_rise;
  logic rel_rise;
  logic rel_fall;
  logic clockwise_sense;
  logic [1:0] choice;
  logic [1:0] motor_d;
  logic [W:0] step_amt;
  logic [W:0] sum_up;
  logic [W:0] sum_dn;
  logic [W-1:0] sp_d;
  logic setup;
  logic wr_en;
  logic addr_ok;
  logic [31:0] rd_d;

  assign raw = {rotate_cmd_in, spindle_choice_input, choice_bit_one, choice_bit_zero,
                error_release_in, step_polarity_input, speed_step_pulse, rotation_sense_in};

  input_conditioner #(
    .N(spindle_io_pkg::NUM_INPUTS),
    .CYC(spindle_io_pkg::DEBOUNCE_CYC)
  ) u_cond (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(raw),
    .clean(cin)
  );

  fault_pattern #(
    .UNIT_CYC(PATTERN_CYC)
  ) u_pat (
    .mclk(mclk),
    .rst_n(rst_n),
    .active(err_q),
    .code(error_code[3:0]),
    .pulse_q(pattern)
  );

  // Edges are taken on the conditioned levels only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_prev_q <= 1'b0;
    end else begin
      step_prev_q <= cin[spindle_io_pkg::IN_STEP];
    end
  end

  // Release history; reset matches the open idle level, so no false edge follows reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rel_prev_q <= 1'b0;
    end else begin
      rel_prev_q <= cin[spindle_io_pkg::IN_REL];
    end
  end
  assign step_rise = cin[spindle_io_pkg::IN_STEP] & ~step_prev_q;
  assign rel_rise = cin[spindle_io_pkg::IN_REL] & ~rel_prev_q;
  assign rel_fall = ~cin[spindle_io_pkg::IN_REL] & rel_prev_q;

  // Release needs open-closed-open; a toggle seen while the cause persists is dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rel_armed_q <= 1'b0;
    end else if (error_cause || !err_q) begin
      rel_armed_q <= 1'b0;
    end else if (rel_rise) begin
      rel_armed_q <= 1'b1;
    end else if (rel_fall) begin
      rel_armed_q <= 1'b0;
    end
  end

  // Error latch: a live cause always wins over a release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (error_cause) begin
      err_q <= 1'b1;
    end else if (rel_fall && rel_armed_q) begin
      err_q <= 1'b0;
    end
  end

  // Step arithmetic with clamping to the speed range
  assign step_amt = {1'b0, ctrl_q[spindle_io_pkg::CB_LARGE_STEP] ?
                    spindle_io_pkg::STEP_LARGE : spindle_io_pkg::STEP_SMALL};
  assign sum_up = {1'b0, pulse_sp_q} + step_amt;
  assign sum_dn = {1'b0, pulse_sp_q} - step_amt;
  always_comb begin
    sp_d = pulse_sp_q;
    if (cin[spindle_io_pkg::IN_POL]) begin
      sp_d = (sum_up > {1'b0, spindle_io_pkg::RPM_MAX}) ?
             spindle_io_pkg::RPM_MAX : sum_up[W-1:0];
    end else begin
      sp_d = (sum_dn[W] || sum_dn < {1'b0, spindle_io_pkg::RPM_MIN}) ?
             spindle_io_pkg::RPM_MIN : sum_dn[W-1:0];
    end
  end

  // Pulse-mode setpoint counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulse_sp_q <= spindle_io_pkg::RPM_RESET;
    end else if (step_rise && !ctrl_q[spindle_io_pkg::CB_PRESET_MODE]) begin
      pulse_sp_q <= sp_d;
    end
  end

  // Choice pair is high bit then low bit; the selector unit takes priority over presets
  assign choice = {cin[spindle_io_pkg::IN_CB1], cin[spindle_io_pkg::IN_CB0]};
  assign clockwise_sense = ~cin[spindle_io_pkg::IN_SENSE];
  always_comb begin
    if (ctrl_q[spindle_io_pkg::CB_SELECTOR]) begin
      motor_d = choice;
    end else begin
      motor_d = {1'b0, cin[spindle_io_pkg::IN_SPINDLE]};
    end
  end

  // Start and direction commands; a latched error holds the motor off
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      motor_start <= 1'b0;
      counter_sense <= 1'b0;
    end else begin
      motor_start <= cin[spindle_io_pkg::IN_ROTATE] & ~err_q;
      counter_sense <= ~clockwise_sense;
    end
  end

  // Motor and preset choice handed to the drive
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_spindle_flag <= 2'h0;
      preset_speed_slot <= 2'h0;
    end else begin
      active_spindle_flag <= motor_d;
      preset_speed_slot <= choice;
    end
  end

  // Setpoint: a preset slot, or the pulse counter; the selector unit disables presets
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      speed_setpoint <= spindle_io_pkg::RPM_RESET;
    end else if (ctrl_q[spindle_io_pkg::CB_PRESET_MODE] &&
                 !ctrl_q[spindle_io_pkg::CB_SELECTOR]) begin
      speed_setpoint <= slot_q[choice];
    end else begin
      speed_setpoint <= pulse_sp_q;
    end
  end

  // Run contact follows the drive, optionally inverted
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_status_out <= 1'b0;
    end else begin
      run_status_out <= motor_rotating ^ ctrl_q[spindle_io_pkg::CB_RUN_INVERT];
    end
  end

  // Shared contact shows either the chosen motor or the commanded direction
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shared_status_out <= 1'b0;
    end else if (ctrl_q[spindle_io_pkg::CB_SHARED_MOTOR]) begin
      shared_status_out <= (motor_d == 2'h1);
    end else begin
      shared_status_out <= cin[spindle_io_pkg::IN_ROTATE] & ~clockwise_sense;
    end
  end

  // Fault contact: static level, or the blink train when enabled
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_out <= 1'b0;
    end else if (ctrl_q[spindle_io_pkg::CB_FAULT_PATTERN]) begin
      fault_out <= pattern;
    end else begin
      fault_out <= ~err_q ^ ctrl_q[spindle_io_pkg::CB_FAULT_INVERT];
    end
  end

  // Error flag and code for the speed display
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      error_latched <= 1'b0;
      display_error <= 1'b0;
      display_code <= 8'h00;
    end else begin
      error_latched <= err_q;
      display_error <= err_q;
      display_code <= err_q ? error_code : 8'h00;
    end
  end

  // APB decode; every access has one wait-free access phase after setup
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  always_comb begin
    addr_ok = 1'b1;
    rd_d = 32'h00000000;
    unique case (paddr)
      spindle_io_pkg::ADDR_CTRL: rd_d = {25'h0000000, ctrl_q};
      spindle_io_pkg::ADDR_SLOT0: rd_d = {15'h0000, slot_q[0]};
      spindle_io_pkg::ADDR_SLOT1: rd_d = {15'h0000, slot_q[1]};
      spindle_io_pkg::ADDR_SLOT2: rd_d = {15'h0000, slot_q[2]};
      spindle_io_pkg::ADDR_SLOT3: rd_d = {15'h0000, slot_q[3]};
      spindle_io_pkg::ADDR_STATUS: rd_d = {20'h00000, error_code, err_q,
                                             active_spindle_flag, motor_start};
      spindle_io_pkg::ADDR_SETPOINT: rd_d = {15'h0000, speed_setpoint};
      default: addr_ok = 1'b0;
    endcase
  end

  // Handshake answer registered in setup so that pready and pslverr come from flops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
    end
  end

  // Read data stands only in the access cycle and reads zero otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (setup && !pwrite) ? rd_d : 32'h00000000;
    end
  end

  // Configuration writes; read-only registers ignore writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= spindle_io_pkg::CTRL_RESET;
      for (int k = 0; k < 4; k++) begin
        slot_q[k] <= spindle_io_pkg::RPM_RESET;
      end
    end else if (wr_en) begin
      unique case (paddr)
        spindle_io_pkg::ADDR_CTRL: ctrl_q <= pwdata[spindle_io_pkg::CTRL_W-1:0];
        spindle_io_pkg::ADDR_SLOT0: slot_q[0] <= pwdata[W-1:0];
        spindle_io_pkg::ADDR_SLOT1: slot_q[1] <= pwdata[W-1:0];
        spindle_io_pkg::ADDR_SLOT2: slot_q[2] <= pwdata[W-1:0];
        spindle_io_pkg::ADDR_SLOT3: slot_q[3] <= pwdata[W-1:0];
        default: ;
      endcase
    end
  end
endmodule : spindle_external_io

/* File: verif/spindle_io_props.sv */
// Port checker of the spindle connector block
`timescale 1ns/100ps
module spindle_io_props #(
  parameter int PATTERN_CYC = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic rotation_sense_in,
  input wire logic rotate_cmd_in,
  input wire logic motor_rotating,
  input wire logic error_cause,
  input wire logic run_status_out,
  input wire logic motor_start,
  input wire logic counter_sense,
  input wire logic [16:0] speed_setpoint,
  input wire logic error_latched,
  input wire logic display_error,
  input wire logic [7:0] display_code
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic wr;
  // A control write may flip the run output by itself
  assign wr = psel && penable && pwrite;
  apb_wait_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  dir_sense_a: assert property (
    $changed(counter_sense) |-> counter_sense == $past(rotation_sense_in, 8))
    else $error("direction output not from its contact");
  motor_start_a: assert property ($rose(motor_start) |-> $past(rotate_cmd_in, 8))
    else $error("start without rotate contact");
  run_follow_a: assert property (
    $changed(motor_rotating) && !$past(wr) |=> $changed(run_status_out))
    else $error("run output missed a motor change");
  err_hold_a: assert property (error_cause |-> ##2 error_latched)
    else $error("error not held while cause present");
  err_clear_a: assert property ($fell(error_latched) |-> !$past(error_cause, 2))
    else $error("error cleared with cause present");
  err_block_a: assert property (error_latched |-> !motor_start)
    else $error("start while error latched");
  err_show_a: assert property (
    display_error == error_latched && (display_error || display_code == 8'h00))
    else $error("error display wrong");
  rpm_range_a: assert property (
    speed_setpoint >= spindle_io_pkg::RPM_MIN && speed_setpoint <= spindle_io_pkg::RPM_MAX)
    else $error("setpoint out of range");
  cover property ($rose(error_latched));
  cover property ($fell(error_latched));
  cover property ($changed(speed_setpoint));
endmodule : spindle_io_props

bind spindle_external_io spindle_io_props #(.PATTERN_CYC(PATTERN_CYC)) i_props (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .rotation_sense_in(rotation_sense_in), .rotate_cmd_in(rotate_cmd_in),
  .motor_rotating(motor_rotating), .error_cause(error_cause),
  .run_status_out(run_status_out), .motor_start(motor_start),
  .counter_sense(counter_sense), .speed_setpoint(speed_setpoint),
  .error_latched(error_latched), .display_error(display_error),
  .display_code(display_code));

/* File: verif/cnc_model.sv */
// Machine controller model driving the connector contacts
`timescale 1ns/100ps
module cnc_model (
  input wire logic mclk,
  output logic [7:0] pins_q
);
  // Contacts are always driven open or closed, never released
  initial pins_q = 8'h00;
  // Change contacts after an edge and hold them; cyc sets how many edges they are held
  task automatic drive(input logic [7:0] v, input int cyc);
    pins_q <= v;
    repeat (cyc) @(posedge mclk);
  endtask : drive
  // Open, closed, open; each level outlasts the input filter
  task automatic pulse(input int idx);
    drive(pins_q | (8'h01 << idx), 1100);
    drive(pins_q & ~(8'h01 << idx), 1100);
  endtask : pulse
endmodule : cnc_model

/* File: verif/spindle_external_io_bench.sv */
// Self-checking bench of the spindle connector block
`timescale 1ns/100ps
module spindle_external_io_bench;
  logic mclk, rst_n, psel, penable, pwrite, motor_rotating, error_cause, err, prev;
  logic pready, pslverr, run_status_out, shared_status_out, fault_out, motor_start;
  logic counter_sense, error_latched, display_error;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] error_code, display_code, pins;
  logic [16:0] speed_setpoint;
  logic [1:0] active_spindle_flag, preset_speed_slot;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int exp_rpm, seed, n, k;
  int slot[4];

  // Short blink unit keeps the pattern check brief
  spindle_external_io #(.PATTERN_CYC(20)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rotation_sense_in(pins[0]), .speed_step_pulse(pins[1]), .step_polarity_input(pins[2]),
    .error_release_in(pins[3]), .choice_bit_zero(pins[4]), .choice_bit_one(pins[5]),
    .spindle_choice_input(pins[6]), .rotate_cmd_in(pins[7]),
    .motor_rotating(motor_rotating), .error_cause(error_cause), .error_code(error_code),
    .run_status_out(run_status_out), .shared_status_out(shared_status_out),
    .fault_out(fault_out), .motor_start(motor_start), .counter_sense(counter_sense),
    .active_spindle_flag(active_spindle_flag), .preset_speed_slot(preset_speed_slot),
    .speed_setpoint(speed_setpoint), .error_latched(error_latched),
    .display_error(display_error), .display_code(display_code));
  cnc_model i_cnc (.mclk(mclk), .pins_q(pins));

  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Hang guard; the run needs about 30000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_out

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask : tick

  // One APB transfer, entered right after an edge; waits for pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // Read and compare data with the error flag above it
  task automatic cmp_bus(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(a, 1'b0, 32'h0);
    cmp_count++;
    if ({err, rd} !== {e, exp}) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, {err, rd}, {e, exp});
    end
  endtask : cmp_bus

  // Control write, then let the outputs follow
  task automatic wr_ctrl(input logic [31:0] v);
    apb(12'h000, 1'b1, v);
    tick(2);
  endtask : wr_ctrl

  // One step pulse; the model clamps at the lower end
  task automatic step(input int d);
    i_cnc.pulse(1);
    exp_rpm = (exp_rpm + d < 1000) ? 1000 : exp_rpm + d;
    cmp_out(32'(speed_setpoint), 32'(exp_rpm));
    cmp_bus(12'h018, 32'(exp_rpm), 1'b0);
  endtask : step

  // Main sequence
  initial begin
    seed = 32'hBD44EFB7;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    motor_rotating = 1'b0;
    error_cause = 1'b0;
    error_code = 8'h00;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    exp_rpm = 1000;
    cmp_bus(12'h000, 32'h0, 1'b0);
    for (n = 1; n < 5; n++) cmp_bus(12'(4 * n), 32'h3E8, 1'b0);
    apb(12'h018, 1'b1, 32'h5);
    cmp_bus(12'h018, 32'h3E8, 1'b0);
    cmp_bus(12'h0FC, 32'h0, 1'b1);
    // Direction, start and motor choice contacts
    i_cnc.drive(8'hC1, 1100);
    cmp_out(32'(counter_sense), 32'h1);
    cmp_out(32'(motor_start), 32'h1);
    cmp_out(32'(shared_status_out), 32'h1);
    cmp_out(32'(active_spindle_flag), 32'h1);
    wr_ctrl(32'h04);
    cmp_out(32'(shared_status_out), 32'h1);
    i_cnc.drive(8'h81, 1100);
    cmp_out(32'(shared_status_out), 32'h0);
    cmp_out(32'(active_spindle_flag), 32'h0);
    wr_ctrl(32'h00);
    i_cnc.drive(8'h01, 1100);
    cmp_out(32'(shared_status_out), 32'h0);
    cmp_out(32'(motor_start), 32'h0);
    i_cnc.drive(8'h00, 1100);
    cmp_out(32'(counter_sense), 32'h0);
    // Run output plain, then inverted
    for (n = 0; n < 8; n++) begin
      if (n == 4) wr_ctrl(32'h02);
      motor_rotating <= 1'($random(seed));
      tick(2);
      cmp_out(32'(run_status_out), 32'(motor_rotating ^ (n > 3)));
    end
    // Steps of both sizes, both ways, clamp and a filtered bounce
    wr_ctrl(32'h00);
    i_cnc.drive(8'h04, 1100);
    step(200);
    wr_ctrl(32'h01);
    step(1000);
    i_cnc.drive(8'h00, 1100);
    step(-1000);
    step(-1000);
    i_cnc.drive(8'h02, 50);
    i_cnc.drive(8'h00, 1100);
    cmp_out(32'(speed_setpoint), 32'(exp_rpm));
    // Preset slots by the pair, then the pair as motor choice
    for (n = 0; n < 4; n++) begin
      slot[n] = 1000 + {$random(seed)} % 79001;
      apb(12'(4 + 4 * n), 1'b1, 32'(slot[n]));
    end
    for (n = 0; n < 4; n++) begin
      wr_ctrl(32'h40);
      i_cnc.drive(8'(n << 4), 1100);
      cmp_out(32'(preset_speed_slot), 32'(n));
      cmp_out(32'(speed_setpoint), 32'(slot[n]));
      wr_ctrl(32'h20);
      cmp_out(32'(active_spindle_flag), 32'(n));
    end
    // Error latch with the rotate contact closed; release refused while the cause stays
    wr_ctrl(32'h00);
    i_cnc.drive(8'h80, 1100);
    cmp_out(32'(motor_start), 32'h1);
    error_code <= 8'($random(seed));
    error_cause <= 1'b1;
    tick(3);
    cmp_out(32'(fault_out), 32'h0);
    cmp_out(32'(display_code), 32'(error_code));
    cmp_out(32'(display_error), 32'h1);
    cmp_out(32'(motor_start), 32'h0);
    i_cnc.pulse(3);
    cmp_out(32'(error_latched), 32'h1);
    wr_ctrl(32'h08);
    cmp_out(32'(fault_out), 32'h1);
    cmp_bus(12'h014, {20'h0, error_code, 4'h8}, 1'b0);
    error_cause <= 1'b0;
    i_cnc.pulse(3);
    cmp_out(32'(error_latched), 32'h0);
    cmp_out(32'(motor_start), 32'h1);
    cmp_out(32'(fault_out), 32'h0);
    wr_ctrl(32'h10);
    cmp_out(32'(fault_out), 32'h0);
    // Blink count over one full pattern period
    error_cause <= 1'b1;
    tick(300);
    k = (error_code[3:0] == 4'h0) ? 1 : int'(error_code[3:0]);
    n = 0;
    prev = fault_out;
    repeat ((2 * k + 4) * 20) begin
      @(posedge mclk);
      if (fault_out === 1'b1 && prev === 1'b0) n++;
      prev = fault_out;
    end
    cmp_out(32'(n), 32'(k));
    report_and_stop();
  end
endmodule : spindle_external_io_bench
